//--- hdl/tpg_timer_pulse_generator.sv
// Behaviour
// - pulse output polarity selectable, low-active or high-active
// - toggle flip-flop inverts on duty or period match, drives pulse pin
// - double buffered duty copied to active duty on period match
// - control bit 7 enables duty double buffering, clear means immediate
// - duty and period are 16-bit, byte writable, compared with counter
// - flip-flop control write can clear output flip-flop before counting
// - mode selects prescaler tick 01/10/11, capture off, clear on period
// - trigger mode code 01 counts rising edges of trigger pin
// - both inversion enables set: invert on either compare match; code leaves the flip-flop unchanged when both match in one cycle
// - run bit set lets counter advance on trigger edges
// - trigger rising edge latches counter into capture zero
// - capture latch raises capture interrupt zero
// - run bit clear stops and zeroes counter, set starts from zero
// - duty match raises compare irq zero, period match irq one
// - command 00 inverts, 01 sets, 10 clears the flip-flop
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module tpg_timer_pulse_generator #(
   parameter int unsigned PRESC_DIV = tpg_pkg::PRESC_DIV_DEF
) (
   input  wire logic                      i_mclk,              // 25 MHz clock
   input  wire logic                      i_nrst,              // sync reset, low active
   input  wire logic [tpg_pkg::ADDR_W-1:0] i_avs_address,      // byte address
   input  wire logic                      i_avs_read,          // read request
   input  wire logic                      i_avs_write,         // write request
   input  wire logic [tpg_pkg::DATA_W-1:0] i_avs_writedata,    // write data
   input  wire logic [3:0]                i_avs_byteenable,    // byte lanes
   output logic      [tpg_pkg::DATA_W-1:0] o_avs_readdata,     // read data
   output logic                           o_avs_waitrequest,   // slave stall
   input  wire logic                      i_trigger_in_pin,    // async trigger pin
   output logic                           o_pulse_out_pin,     // pulse output
   output logic                           o_compare_irq_zero,  // duty match pulse
   output logic                           o_compare_irq_one,   // period match pulse
   output logic                           o_capture_irq_zero   // capture pulse
);
   import tpg_pkg::*;

   typedef struct packed {
      logic [1:0]  trig_sync;
      logic        trig_prev;
      logic        en;
      logic        run;
      logic        psc_run;
      logic        dbuf;
      logic        pol;
      logic [1:0]  trig_start;
      logic [1:0]  clk_sel;
      logic        clr_match;
      logic [1:0]  cap_mode;
      logic        inv_duty;
      logic        inv_period;
      logic        toggle;
      logic [15:0] cnt;
      logic        adv;
      logic [15:0] duty_buf;
      logic [15:0] duty;
      logic [15:0] period;
      logic [15:0] cap0;
      logic        irq0;
      logic        irq1;
      logic        irqc;
      logic        out;
      logic        ack;
      logic [31:0] rdata;
   } tpg_state_t;

   tpg_state_t s;
   tpg_state_t n;

   logic        req;
   logic        wr_take;
   logic [3:0]  widx;
   logic        ext_edge;
   logic        cnt_en;
   logic        ext_mode;
   logic        psc_tick;
   logic        cnt_evt;
   logic        m_duty;
   logic        m_period;
   logic        hw_toggle;
   logic [15:0] wr16;

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   function automatic logic [31:0] rd_mux(input tpg_state_t st, input logic [3:0] idx);
      case (idx)
         OFS_ENABLE[5:2]:   rd_mux = {24'h000000, st.en, 7'h00};
         OFS_RUN[5:2]:      rd_mux = {29'h00000000, st.psc_run, 1'b0, st.run};
         OFS_CTRL[5:2]:     rd_mux = {24'h000000, st.dbuf, 1'b0, st.pol, 3'h0, st.trig_start};
         OFS_MODE[5:2]:     rd_mux = {27'h0000000, st.cap_mode, st.clr_match, st.clk_sel};
         OFS_FFCTRL[5:2]:   rd_mux = {27'h0000000, st.toggle, st.inv_period, st.inv_duty,
                                      2'h3};
         OFS_DUTY[5:2]:     rd_mux = {16'h0000, st.duty};
         OFS_PERIOD[5:2]:   rd_mux = {16'h0000, st.period};
         OFS_CAPTURE[5:2]:  rd_mux = {16'h0000, st.cap0};
         OFS_SNAPSHOT[5:2]: rd_mux = {16'h0000, st.cnt};
         default:           rd_mux = 32'h00000000;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait state, read data registered in that wait state

   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~s.ack;
   assign wr_take = i_avs_write & s.ack;
   assign widx = i_avs_address[ADDR_W-1:2];
   assign wr16 = merge16(s.duty_buf, i_avs_writedata, i_avs_byteenable);

   ////////////////////////////////////////////////////////////////////////////
   // count source and compare

   tpg_prescaler #(
      .DIV (PRESC_DIV)
   ) u_prescaler (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .i_run  (s.en & s.psc_run),
      .i_sel  (s.clk_sel),
      .o_tick (psc_tick)
   );

   assign ext_edge = s.trig_sync[1] & ~s.trig_prev;
   assign cnt_en = s.en & s.run;
   assign ext_mode = (s.trig_start == TRIG_EXT) | (s.clk_sel == CLK_EXT);
   assign cnt_evt = cnt_en & (ext_mode ? ext_edge : psc_tick);
   // compare right after a count step (increment or clear) only, and only while running: no stray irq after stop
   assign m_duty = s.adv & cnt_en & (s.cnt == s.duty);
   assign m_period = s.adv & cnt_en & (s.cnt == s.period);
   assign hw_toggle = (m_duty & s.inv_duty) ^ (m_period & s.inv_period);

   always_comb begin
      n = s;
      n.trig_sync = {s.trig_sync[0], i_trigger_in_pin};
      n.trig_prev = s.trig_sync[1];
      n.ack = req & ~s.ack;
      n.irq0 = m_duty;
      n.irq1 = m_period;
      n.irqc = 1'b0;
      n.adv = 1'b0;
      if (!s.ack) begin
         n.rdata = rd_mux(s, widx);
      end
      if (!cnt_en) begin
         n.cnt = 16'h0000;
      end else if (cnt_evt) begin
         n.adv = 1'b1;
         if (s.clr_match && (s.cnt == s.period)) begin
            n.cnt = 16'h0000;
         end else begin
            n.cnt = s.cnt + 16'h0001;
         end
      end
      if (s.en && (s.cap_mode == CAP_RISE) && ext_edge) begin
         n.cap0 = s.cnt;
         n.irqc = 1'b1;
      end
      if (hw_toggle) begin
         n.toggle = ~s.toggle;
      end
      if (m_period && s.dbuf) begin
         n.duty = s.duty_buf;
      end
      if (wr_take && i_avs_byteenable[0]) begin
         case (widx)
            OFS_ENABLE[5:2]: n.en = i_avs_writedata[EN_BIT];
            OFS_RUN[5:2]: begin
               n.run = i_avs_writedata[RUN_BIT];
               n.psc_run = i_avs_writedata[PSC_RUN_BIT];
            end
            OFS_CTRL[5:2]: begin
               n.dbuf = i_avs_writedata[DBUF_BIT];
               n.pol = i_avs_writedata[POL_BIT];
               n.trig_start = i_avs_writedata[TRIG_LSB+:2];
            end
            OFS_MODE[5:2]: begin
               n.clk_sel = i_avs_writedata[CLKSEL_LSB+:2];
               n.clr_match = i_avs_writedata[CLR_BIT];
               n.cap_mode = i_avs_writedata[CAPM_LSB+:2];
            end
            OFS_FFCTRL[5:2]: begin
               n.inv_duty = i_avs_writedata[INV_DUTY_BIT];
               n.inv_period = i_avs_writedata[INV_PER_BIT];
               // a software command overrides a match toggle in the same cycle
               case (i_avs_writedata[FFCMD_LSB+:2])
                  FF_INVERT: n.toggle = ~s.toggle;
                  FF_SET:    n.toggle = 1'b1;
                  FF_CLEAR:  n.toggle = 1'b0;
                  default:   n.toggle = n.toggle;
               endcase
            end
            default: n.en = n.en;
         endcase
      end
      if (wr_take) begin
         case (widx)
            OFS_DUTY[5:2]: begin
               n.duty_buf = wr16;
               // a stopped counter makes the buffer transparent
               if (!(s.dbuf && cnt_en)) begin
                  n.duty = wr16;
               end
            end
            OFS_PERIOD[5:2]: n.period = merge16(s.period, i_avs_writedata,
                                                i_avs_byteenable);
            default: n.period = n.period;
         endcase
      end
      n.out = n.toggle ^ n.pol;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         s <= '0;
         s.clk_sel <= RST_CLKSEL;
         s.cap_mode <= RST_CAPM;
         s.duty_buf <= RST_CMP;
         s.duty <= RST_CMP;
         s.period <= RST_CMP;
      end else begin
         s <= n;
      end
   end

   assign o_avs_readdata = s.rdata;
   assign o_pulse_out_pin = s.out;
   assign o_compare_irq_zero = s.irq0;
   assign o_compare_irq_one = s.irq1;
   assign o_capture_irq_zero = s.irqc;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   a_period_clear: assert property (cnt_evt && s.clr_match && (s.cnt == s.period)
      |=> (s.cnt == 16'h0000) && s.adv) else $error("counter not cleared on period");
   a_stop_zero: assert property (!cnt_en |=> (s.cnt == 16'h0000) && !o_compare_irq_one)
      else $error("stopped counter not zero");
   a_wrap_max: assert property (cnt_evt && !s.clr_match && (s.cnt == 16'hFFFF)
      |=> s.cnt == 16'h0000) else $error("counter did not wrap");
   a_edge_count: assert property (cnt_en && ext_mode && ext_edge && !wr_take
      && !(s.clr_match && (s.cnt == s.period)) |=> s.cnt == $past(s.cnt) + 16'h0001)
      else $error("trigger edge not counted");
   a_irq_match: assert property (m_duty |=> o_compare_irq_zero ##1 !o_compare_irq_zero)
      else $error("duty match irq wrong");
   a_irq_period: assert property (m_period |=> o_compare_irq_one)
      else $error("period match irq missing");
   a_single_pulse: assert property (o_compare_irq_one |=> !o_compare_irq_one)
      else $error("period irq longer than one cycle");
   a_both_toggle: assert property (s.inv_duty && s.inv_period && (m_duty ^ m_period)
      && !(wr_take && (widx == OFS_FFCTRL[5:2])) |=> s.toggle != $past(s.toggle))
      else $error("flip-flop did not invert on match");
   a_dbuf_load: assert property (m_period && s.dbuf && !(wr_take && (widx == OFS_DUTY[5:2]))
      |=> s.duty == $past(s.duty_buf)) else $error("buffered duty not loaded");
   a_dbuf_hold: assert property (s.dbuf && cnt_en && !m_period && wr_take
      && (widx == OFS_DUTY[5:2]) |=> s.duty == $past(s.duty))
      else $error("buffered duty written through");
   a_capture_latch: assert property (s.en && (s.cap_mode == CAP_RISE) && ext_edge
      |=> (s.cap0 == $past(s.cnt)) && o_capture_irq_zero) else $error("capture failed");
   a_ff_clear: assert property (wr_take && i_avs_byteenable[0] && (widx == OFS_FFCTRL[5:2])
      && (i_avs_writedata[1:0] == FF_CLEAR) |=> !s.toggle && (o_pulse_out_pin == s.pol))
      else $error("flip-flop not cleared");
   a_ff_set: assert property (wr_take && i_avs_byteenable[0] && (widx == OFS_FFCTRL[5:2])
      && (i_avs_writedata[1:0] == FF_SET) |=> s.toggle) else $error("flip-flop not set");
   a_ff_invert: assert property (wr_take && i_avs_byteenable[0]
      && (widx == OFS_FFCTRL[5:2]) && (i_avs_writedata[1:0] == FF_INVERT)
      |=> s.toggle != $past(s.toggle)) else $error("flip-flop not inverted");
   a_duty_quiet: assert property (!m_duty |=> !o_compare_irq_zero)
      else $error("duty irq without match");
   a_period_quiet: assert property (!m_period |=> !o_compare_irq_one)
      else $error("period irq without match");
   a_dbuf_direct: assert property (wr_take && (widx == OFS_DUTY[5:2])
      && !(s.dbuf && cnt_en) |=> s.duty == $past(wr16))
      else $error("duty write not immediate");
   a_capture_quiet: assert property (!(s.en && (s.cap_mode == CAP_RISE) && ext_edge)
      |=> !o_capture_irq_zero) else $error("capture irq without capture");
   a_run_zero: assert property (wr_take && i_avs_byteenable[0] && (widx == OFS_RUN[5:2])
      && !i_avs_writedata[RUN_BIT] |=> ##1 s.cnt == 16'h0000) else $error("run clear kept count");
   a_read_period: assert property (i_avs_read && o_avs_waitrequest
      && (widx == OFS_PERIOD[5:2]) |=> o_avs_readdata == {16'h0000, $past(s.period)})
      else $error("period read back wrong");

   c_period_match: cover property (m_period && s.clr_match ##[1:40] s.cnt == 16'h0000);
   c_capture: cover property (o_capture_irq_zero);
   c_one_shot: cover property (ext_mode && m_duty ##[1:200] m_period);
   c_dbuf: cover property (m_period && s.dbuf && (s.duty != s.duty_buf));
   c_tap_slow: cover property ((s.clk_sel == CLK_T16) && m_period);
endmodule // tpg_timer_pulse_generator
`default_nettype wire

//--- inc/tpg_pkg.sv
`default_nettype none
package tpg_pkg;
   // bus geometry
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int CLK_SEL_W = 2;
   // register byte offsets
   localparam logic [5:0] OFS_ENABLE = 6'h00;
   localparam logic [5:0] OFS_RUN = 6'h04;
   localparam logic [5:0] OFS_CTRL = 6'h08;
   localparam logic [5:0] OFS_MODE = 6'h0C;
   localparam logic [5:0] OFS_FFCTRL = 6'h10;
   localparam logic [5:0] OFS_DUTY = 6'h14;
   localparam logic [5:0] OFS_PERIOD = 6'h18;
   localparam logic [5:0] OFS_CAPTURE = 6'h1C;
   localparam logic [5:0] OFS_SNAPSHOT = 6'h20;
   // field positions
   localparam int EN_BIT = 7;
   localparam int RUN_BIT = 0;
   localparam int PSC_RUN_BIT = 2;
   localparam int DBUF_BIT = 7;
   localparam int POL_BIT = 5;
   localparam int TRIG_LSB = 0;
   localparam int CLKSEL_LSB = 0;
   localparam int CLR_BIT = 2;
   localparam int CAPM_LSB = 3;
   localparam int FFCMD_LSB = 0;
   localparam int INV_DUTY_BIT = 2;
   localparam int INV_PER_BIT = 3;
   // codes
   localparam logic [1:0] CLK_EXT = 2'h0;
   localparam logic [1:0] CLK_T1 = 2'h1;
   localparam logic [1:0] CLK_T4 = 2'h2;
   localparam logic [1:0] CLK_T16 = 2'h3;
   localparam logic [1:0] TRIG_EXT = 2'h1;
   localparam logic [1:0] CAP_RISE = 2'h1;
   localparam logic [1:0] FF_INVERT = 2'h0;
   localparam logic [1:0] FF_SET = 2'h1;
   localparam logic [1:0] FF_CLEAR = 2'h2;
   // reset values
   localparam logic [15:0] RST_CMP = 16'h0000;
   localparam logic [1:0] RST_CLKSEL = 2'h0;
   localparam logic [1:0] RST_CAPM = 2'h0;
   // prescaler: first tick divides the clock by this count
   localparam int unsigned PRESC_DIV_DEF = 2;
endpackage
`default_nettype wire

//--- hdl/tpg_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module tpg_prescaler #(
   parameter int unsigned DIV = tpg_pkg::PRESC_DIV_DEF
) (
   input  wire logic                         i_mclk,  // system clock
   input  wire logic                         i_nrst,  // sync reset, low active
   input  wire logic                         i_run,   // prescaler running
   input  wire logic [tpg_pkg::CLK_SEL_W-1:0] i_sel,  // tick select code
   output logic                              o_tick   // one-cycle count tick
);
   import tpg_pkg::*;

   localparam int CW = $clog2(DIV + 1);

   typedef struct packed {
      logic [CW-1:0] base;
      logic [3:0]    t1n;
      logic          tick;
   } tpg_psc_state_t;

   tpg_psc_state_t s;
   tpg_psc_state_t n;

   always_comb begin
      logic t1;
      t1 = 1'b0;
      n = s;
      if (!i_run) begin
         n.base = '0;
         n.t1n = 4'h0;
      end else if (s.base == CW'(DIV - 1)) begin
         n.base = '0;
         n.t1n = s.t1n + 4'h1;
         t1 = 1'b1;
      end else begin
         n.base = s.base + CW'(1);
      end
      // slower ticks are decimations of the fastest, so all stay phase aligned
      case (i_sel)
         CLK_T1:  n.tick = t1;
         CLK_T4:  n.tick = t1 & (s.t1n[1:0] == 2'h3);
         CLK_T16: n.tick = t1 & (s.t1n == 4'hF);
         default: n.tick = 1'b0;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign o_tick = s.tick;
endmodule // tpg_prescaler
`default_nettype wire

//--- testbench/tpg_trig_src.sv
`timescale 1ns/1ns
`default_nettype none
// far-side trigger source: sends i_n rising edges on request, idles low
module tpg_trig_src (
   input  wire logic       i_mclk,  // system clock
   input  wire logic       i_nrst,  // sync reset, low active
   input  wire logic [3:0] i_n,     // edges to send
   input  wire logic       i_go,    // start request
   input  wire logic       i_slow,  // long phases instead of short
   output logic            o_pin,   // trigger pin level
   output logic            o_busy   // edges still pending
);
   logic [3:0] left;
   logic [3:0] ph;
   // phases stay well above the two-flop synchroniser so every edge is seen
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         left  <= 4'h0;
         ph    <= 4'h0;
         o_pin <= 1'b0;
      end else if (left == 4'h0) begin
         o_pin <= 1'b0;
         ph    <= 4'h0;
         if (i_go) left <= i_n;
      end else if (ph == (i_slow ? 4'hB : 4'h3)) begin
         ph    <= 4'h0;
         o_pin <= !o_pin;
         if (o_pin) left <= left - 4'h1;
      end else begin
         ph <= ph + 4'h1;
      end
   end
   assign o_busy = (left != 4'h0);
endmodule // tpg_trig_src
`default_nettype wire

//--- testbench/tpg_timer_pulse_generator_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tpg_timer_pulse_generator_tb_top;
   import tpg_pkg::*;
   logic        i_mclk, i_nrst, av_rd, av_wr, go, slow, wreq, pin, irq0, irq1, capi, trig, tbusy;
   logic [5:0]  av_a;
   logic [31:0] av_wd, av_rdata, rv;
   logic [3:0]  av_be, tn;
   logic [15:0] c0, cp;
   int          n_mismatch, n_tests, n;
   localparam logic [7:0] PC [6] = '{8'h00, 8'h20, 8'h20, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] PF [6] = '{8'h01, 8'h01, 8'h02, 8'h00, 8'h00, 8'h03};
   localparam logic [5:0] PE = 6'b001101;
   tpg_timer_pulse_generator #(.PRESC_DIV(2)) dut (.i_mclk(i_mclk), .i_nrst(i_nrst),
      .i_avs_address(av_a), .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
      .i_avs_byteenable(av_be), .o_avs_readdata(av_rdata), .o_avs_waitrequest(wreq),
      .i_trigger_in_pin(trig), .o_pulse_out_pin(pin), .o_compare_irq_zero(irq0),
      .o_compare_irq_one(irq1), .o_capture_irq_zero(capi));
   tpg_trig_src src (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_n(tn), .i_go(go), .i_slow(slow),
      .o_pin(trig), .o_busy(tbusy));
   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one bus access; held until waitrequest is seen low at a rising edge, data taken there
   task automatic acc(input logic we, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge i_mclk);
      av_wr <= we;
      av_rd <= !we;
      av_a  <= a;
      av_wd <= d;
      av_be <= be;
      do begin
         @(posedge i_mclk);
      end while (wreq !== 1'b0);
      rv = av_rdata;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      acc(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0, 4'hF);
      chk(rv, exp);
   endtask
   // waits for an interrupt pulse, returns the cycles it took
   task automatic wirq(input int s, output int c);
      c = 0;
      do begin
         @(negedge i_mclk);
         c++;
      end while ((s == 0 ? irq0 : s == 1 ? irq1 : capi) !== 1'b1 && c < 400);
      if (c >= 400) chk(32'h1, 32'h0);
   endtask
   task automatic pinis(input logic exp);
      @(negedge i_mclk);
      chk({31'h0, pin}, {31'h0, exp});
   endtask
   task automatic fire(input logic [3:0] cnt, input logic s);
      @(posedge i_mclk);
      go   <= 1'b1;
      tn   <= cnt;
      slow <= s;
      @(posedge i_mclk);
      go <= 1'b0;
   endtask
   task automatic tdone;
      int k;
      k = 0;
      repeat (2) @(posedge i_mclk);
      while (tbusy && k < 500) begin
         @(posedge i_mclk);
         k++;
      end
      repeat (6) @(posedge i_mclk);
   endtask
   task automatic wrap_up;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // whole run is several hundred cycles
   initial begin
      repeat (20000) @(posedge i_mclk);
      n_mismatch++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {av_rd, av_wr, go, slow} = 4'h0;
      av_a = 6'h00;
      av_wd = 32'h0;
      av_be = 4'h0;
      tn = 4'h0;
      i_nrst = 1'b0;
      repeat (2) @(posedge i_mclk);
      i_nrst <= 1'b1;
      rd(OFS_DUTY, 32'h0);
      wr(6'h3C, 32'hFFFF);
      rd(6'h3C, 32'h0);
      wr(OFS_CAPTURE, 32'hFFFF);
      rd(OFS_CAPTURE, 32'h0);
      wr(OFS_ENABLE, 32'h80);
      acc(1'b1, OFS_PERIOD, 32'h1200, 4'h2);
      acc(1'b1, OFS_PERIOD, 32'h34, 4'h1);
      rd(OFS_PERIOD, 32'h1234);
      $display("registers done");
      for (int i = 0; i < 6; i++) begin
         wr(OFS_CTRL, {24'h0, PC[i]});
         wr(OFS_FFCTRL, {24'h0, PF[i]});
         repeat (2) @(posedge i_mclk);
         pinis(PE[i]);
      end
      rd(OFS_FFCTRL, 32'h03);
      $display("flip-flop commands done");
      wr(OFS_CTRL, 32'h0);
      wr(OFS_DUTY, 32'h2);
      wr(OFS_PERIOD, 32'h5);
      wr(OFS_FFCTRL, 32'h0E);
      pinis(1'b0);
      wr(OFS_MODE, 32'h05);
      wr(OFS_RUN, 32'h05);
      wirq(1, n);
      wirq(0, n);
      chk(n, 6);
      pinis(1'b1);
      wirq(1, n);
      chk(n, 5);
      pinis(1'b0);
      wirq(1, n);
      chk(n, 11);
      // buffered duty must not land before the next period match
      wr(OFS_CTRL, 32'h80);
      wirq(1, n);
      wr(OFS_DUTY, 32'h3);
      rd(OFS_DUTY, 32'h2);
      wirq(1, n);
      rd(OFS_DUTY, 32'h3);
      wirq(1, n);
      wirq(0, n);
      chk(n, 8);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_DUTY, 32'h1);
      rd(OFS_DUTY, 32'h1);
      wr(OFS_RUN, 32'h0);
      rd(OFS_SNAPSHOT, 32'h0);
      $display("square wave done");
      wr(OFS_MODE, 32'h0);
      wr(OFS_CTRL, 32'h01);
      wr(OFS_DUTY, 32'h2);
      wr(OFS_PERIOD, 32'h4);
      wr(OFS_FFCTRL, 32'h0E);
      wr(OFS_RUN, 32'h1);
      fire(4'h2, 1'b0);
      tdone();
      pinis(1'b1);
      rd(OFS_SNAPSHOT, 32'h2);
      fire(4'h2, 1'b1);
      tdone();
      pinis(1'b0);
      rd(OFS_SNAPSHOT, 32'h4);
      wr(OFS_FFCTRL, 32'h03);
      wr(OFS_RUN, 32'h0);
      $display("trigger one-shot done");
      wr(OFS_CTRL, 32'h0);
      wr(OFS_FFCTRL, 32'h02);
      wr(OFS_MODE, 32'h09);
      wr(OFS_RUN, 32'h05);
      acc(1'b0, OFS_SNAPSHOT, 32'h0, 4'hF);
      c0 = rv[15:0];
      fire(4'h1, 1'b0);
      wirq(2, n);
      acc(1'b0, OFS_CAPTURE, 32'h0, 4'hF);
      cp = rv[15:0];
      chk({31'h0, (cp - c0) < 16'h0014}, 32'h1);
      wr(OFS_DUTY, {16'h0, cp + 16'h0028});
      wr(OFS_PERIOD, {16'h0, cp + 16'h003C});
      wr(OFS_FFCTRL, 32'h0F);
      wirq(0, n);
      pinis(1'b1);
      wirq(1, n);
      pinis(1'b0);
      wr(OFS_FFCTRL, 32'h03);
      wr(OFS_RUN, 32'h0);
      $display("capture one-shot done");
      // slower taps: period 1 with clear gives a match every second tick
      wr(OFS_DUTY, 32'h0);
      wr(OFS_PERIOD, 32'h1);
      wr(OFS_MODE, 32'h06);
      wr(OFS_RUN, 32'h05);
      wirq(1, n);
      wirq(1, n);
      chk(n, 16);
      wr(OFS_MODE, 32'h07);
      wirq(1, n);
      wirq(1, n);
      chk(n, 64);
      wr(OFS_RUN, 32'h0);
      $display("prescaler taps done");
      wrap_up();
   end
endmodule // tpg_timer_pulse_generator_tb_top
`default_nettype wire
